// *** core/dle_status_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module dle_status_encoder
   import dle_pkg::*;
#(
   parameter int FAST_CYC = FAST_HALF_CYC, // Fast half period in cycles
   parameter int SLOW_CYC = SLOW_HALF_CYC // Slow half period in cycles
) (
   input wire logic clk, // System clock
   input wire logic reset, // Asynchronous reset
   input wire logic kbus_active, // Terminal bus cycles running
   input wire logic emc_fault, // Disturbance on terminal bus
   input wire logic nv_checksum_fault, // Stored configuration bad
   input wire logic code_overflow, // Too many table entries
   input wire logic unknown_type, // Unknown data type
   input wire logic command_fault, // Terminal bus command failed
   input wire logic chain_break, // Terminal chain broken
   input wire logic [COUNT_W-1:0] break_pos, // Terminal before break
   input wire logic reg_comm_fault, // Register access failed
   input wire logic [COUNT_W-1:0] reg_term, // Terminal of failed access
   input wire logic init_fault, // Initialisation failed
   input wire logic internal_fault, // Internal data error
   input wire logic switch_changed, // Address switches moved
   input wire logic cycle_overrun, // Cycle time exceeded
   input wire logic program_fault, // Program flash checksum bad
   input wire logic library_fault, // Faulty library
   input wire logic config_mismatch, // Terminal differs from boot set
   input wire logic [COUNT_W-1:0] mismatch_term, // Differing terminal
   input wire logic format_fault, // Terminal reports wrong format
   input wire logic [COUNT_W-1:0] format_term, // Terminal with bad format
   input wire logic count_fault, // Terminal count changed
   input wire logic [COUNT_W-1:0] count_found, // Terminals detected
   input wire logic length_fault, // Process data length changed
   input wire logic [COUNT_W-1:0] length_found, // Length detected
   input wire logic fb_baud_search, // Searching for baud rate
   input wire logic fb_bus_off, // Controller is bus-off
   input wire logic fb_warning, // Error counters at warning level
   input wire dle_nmt_t fb_nmt_state, // Network state
   input wire logic fb_guard_err, // Guarding error
   input wire logic fb_sync_err, // Sync error
   input wire logic fb_event_timeout, // Event timeout
   output logic kbus_run_lamp, // Terminal bus run lamp
   output logic kbus_err_lamp, // Terminal bus error lamp
   output logic fieldbus_run_lamp, // Fieldbus run lamp
   output logic fieldbus_fault_lamp, // Fieldbus fault lamp
   output logic fieldbus_diag_lamp // Fieldbus diagnostic lamp
);
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   if (FAST_CYC < 2 || SLOW_CYC < FAST_CYC ||
       SLOW_CYC >= (1 << PRESCALE_W)) begin : g_bad_period
      $error("dle_status_encoder: flash periods out of range");
   end

   function automatic logic [PRESCALE_W-1:0] wrap_next(
      input logic [PRESCALE_W-1:0] cnt,
      input int lim
   );
      logic [PRESCALE_W-1:0] top;
      top = PRESCALE_W'(lim - 1);
      wrap_next = (cnt == top) ? '0 : cnt + 1'b1;
   endfunction : wrap_next

   // ****************************************************************
   // Flash timebase
   // ****************************************************************
   logic [PRESCALE_W-1:0] fast_cnt_r, slow_cnt_r;
   logic fast_tick_r, slow_tick_r, slow_phase_r;
   wire fast_wrap_w;
   wire slow_wrap_w;

   assign fast_wrap_w = (wrap_next(fast_cnt_r, FAST_CYC) == '0);
   assign slow_wrap_w = (wrap_next(slow_cnt_r, SLOW_CYC) == '0);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fast_cnt_r <= '0;
         slow_cnt_r <= '0;
         fast_tick_r <= 1'b0;
         slow_tick_r <= 1'b0;
      end else begin
         fast_cnt_r <= wrap_next(fast_cnt_r, FAST_CYC);
         slow_cnt_r <= wrap_next(slow_cnt_r, SLOW_CYC);
         fast_tick_r <= fast_wrap_w;
         slow_tick_r <= slow_wrap_w;
      end
   end

   // Square wave for the bus-off flash
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slow_phase_r <= 1'b0;
      end else if (slow_tick_r) begin
         slow_phase_r <= ~slow_phase_r;
      end
   end

   // ****************************************************************
   // Terminal bus error selection
   // ****************************************************************
   logic overrun_r;
   logic err_any_r;
   logic [4:0] err_code_r;
   logic [COUNT_W-1:0] err_arg_r;
   wire err_any_w;
   wire [4+COUNT_W:0] err_sel_w;
   wire err_lamp_w;
   wire err_busy_w;

   // Overrun holds until reset, the only reboot this logic sees
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         overrun_r <= 1'b0;
      end else if (cycle_overrun) begin
         overrun_r <= 1'b1;
      end
   end

   assign err_any_w = emc_fault | nv_checksum_fault | code_overflow | unknown_type |
                      command_fault | chain_break | reg_comm_fault | init_fault |
                      internal_fault | switch_changed | overrun_r | program_fault |
                      library_fault | config_mismatch | format_fault | count_fault |
                      length_fault;

   // Lowest code wins when several faults stand together
   assign err_sel_w =
      emc_fault ? {ERR_EMC, ARG_ZERO} :
      nv_checksum_fault ? {ERR_CONFIG, ARG_ZERO} :
      code_overflow ? {ERR_CONFIG, ARG_ONE} :
      unknown_type ? {ERR_CONFIG, ARG_TWO} :
      command_fault ? {ERR_COMMAND, ARG_ZERO} :
      chain_break ? {ERR_BREAK, break_pos} :
      reg_comm_fault ? {ERR_REG_COMM, reg_term} :
      init_fault ? {ERR_INTERNAL, ARG_ZERO} :
      internal_fault ? {ERR_INTERNAL, ARG_ONE} :
      switch_changed ? {ERR_INTERNAL, ARG_TWO} :
      overrun_r ? {ERR_CYCLE, ARG_ZERO} :
      program_fault ? {ERR_PROGRAM, ARG_ZERO} :
      library_fault ? {ERR_PROGRAM, ARG_ONE} :
      config_mismatch ? {ERR_MISMATCH, mismatch_term} :
      format_fault ? {ERR_FORMAT, format_term} :
      count_fault ? {ERR_COUNT, count_found} :
      length_fault ? {ERR_LENGTH, length_found} :
      {ERR_EMC, ARG_ZERO};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         err_any_r <= 1'b0;
         err_code_r <= '0;
         err_arg_r <= '0;
      end else begin
         err_any_r <= err_any_w;
         err_code_r <= err_sel_w[4+COUNT_W:COUNT_W];
         err_arg_r <= err_sel_w[COUNT_W-1:0];
      end
   end

   dle_pulse_train u_err_train (
      .clk(clk),
      .reset(reset),
      .fast_tick(fast_tick_r),
      .slow_tick(slow_tick_r),
      .enable(err_any_r),
      .count_a({3'h0, err_code_r}),
      .count_b(err_arg_r),
      .lamp(err_lamp_w),
      .busy(err_busy_w)
   );

   // ****************************************************************
   // Fieldbus decode
   // ****************************************************************
   wire fb_err_w;
   wire fb_quiet_w;
   wire fb_run_w;
   wire fb_fault_w;
   wire fb_diag_w;
   wire diag_lamp_w;
   wire [COUNT_W-1:0] diag_count_w;

   assign fb_err_w = fb_guard_err | fb_sync_err | fb_event_timeout;
   assign fb_quiet_w = fb_baud_search | fb_bus_off | fb_warning;
   assign diag_count_w = fb_guard_err ? DIAG_GUARD :
                         fb_sync_err ? DIAG_SYNC : DIAG_EVENT;
   assign fb_run_w = !fb_quiet_w;
   assign fb_fault_w = fb_baud_search ? 1'b0 :
                       fb_bus_off ? slow_phase_r :
                       fb_warning ? 1'b1 :
                       fb_err_w ? 1'b1 :
                       (fb_nmt_state != NMT_OPERATIONAL);
   assign fb_diag_w = (fb_baud_search | fb_bus_off) ? 1'b0 :
                      fb_warning ? 1'b1 :
                      fb_err_w ? diag_lamp_w : 1'b0;

   dle_pulse_train u_diag_train (
      .clk(clk),
      .reset(reset),
      .fast_tick(fast_tick_r),
      .slow_tick(slow_tick_r),
      .enable(fb_err_w && !fb_quiet_w),
      .count_a(diag_count_w),
      .count_b(ARG_ZERO),
      .lamp(diag_lamp_w),
      .busy()
   );

   // ****************************************************************
   // Lamp registers
   // ****************************************************************
   logic kbus_run_r, kbus_err_r, fb_run_r, fb_fault_r, fb_diag_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         kbus_run_r <= 1'b0;
         kbus_err_r <= 1'b0;
         fb_run_r <= 1'b0;
         fb_fault_r <= 1'b0;
         fb_diag_r <= 1'b0;
      end else begin
         kbus_run_r <= kbus_active;
         kbus_err_r <= err_lamp_w;
         fb_run_r <= fb_run_w;
         fb_fault_r <= fb_fault_w;
         fb_diag_r <= fb_diag_w;
      end
   end

   assign kbus_run_lamp = kbus_run_r;
   assign kbus_err_lamp = kbus_err_r;
   assign fieldbus_run_lamp = fb_run_r;
   assign fieldbus_fault_lamp = fb_fault_r;
   assign fieldbus_diag_lamp = fb_diag_r;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence baud_held;
      fb_baud_search [*2];
   endsequence

   sequence oper_held;
      (!fb_quiet_w && !fb_err_w && fb_nmt_state == NMT_OPERATIONAL) [*2];
   endsequence

   sequence stop_held;
      (!fb_quiet_w && !fb_err_w && fb_nmt_state != NMT_OPERATIONAL) [*2];
   endsequence

   sequence warn_held;
      (fb_warning && !fb_baud_search && !fb_bus_off) [*2];
   endsequence

   kbus_run_dark_a: assert property (!kbus_active [*2] |-> !kbus_run_lamp)
      else $error("run lamp lit without terminal bus cycles");

   err_dark_a: assert property (!err_any_r [*3] ##1 !err_busy_w |-> !kbus_err_lamp)
      else $error("error lamp lit with no error");

   emc_code_a: assert property (emc_fault |=> err_code_r == ERR_EMC && err_arg_r == ARG_ZERO)
      else $error("disturbance not shown as code 0");

   break_code_a: assert property (chain_break &&
      {emc_fault, nv_checksum_fault, code_overflow, unknown_type, command_fault} == 5'h00
      |=> err_code_r == ERR_BREAK && err_arg_r == $past(break_pos))
      else $error("chain break code or position wrong");

   overrun_hold_a: assert property ($rose(overrun_r) |=> overrun_r [*8])
      else $error("cycle overrun indication not held");

   baud_dark_a: assert property (baud_held |=>
      !fieldbus_run_lamp && !fieldbus_fault_lamp && !fieldbus_diag_lamp)
      else $error("lamps not dark during baud search");

   bus_off_flash_a: assert property (fb_bus_off && !fb_baud_search && slow_tick_r
      ##1 (fb_bus_off && !fb_baud_search) [*2] |->
      fieldbus_fault_lamp != $past(fieldbus_fault_lamp) && !fieldbus_run_lamp)
      else $error("bus-off fault lamp not flashing");

   oper_lamps_a: assert property (oper_held |=>
      fieldbus_run_lamp && !fieldbus_fault_lamp && !fieldbus_diag_lamp)
      else $error("operational pattern wrong");

   stop_lamps_a: assert property (stop_held |=>
      fieldbus_run_lamp && fieldbus_fault_lamp && !fieldbus_diag_lamp)
      else $error("stopped pattern wrong");

   guard_lamps_a: assert property ((fb_guard_err && !fb_quiet_w) [*2] |=>
      fieldbus_run_lamp && fieldbus_fault_lamp)
      else $error("guarding error pattern wrong");

   fast_tick_a: assert property (fast_tick_r |=> !fast_tick_r)
      else $error("fast prescaler tick too long");

   slow_pace_a: assert property (slow_tick_r |-> slow_cnt_r == PRESCALE_W'(0))
      else $error("slow tick out of step with prescaler");

   run_lit_a: assert property (kbus_active |=> kbus_run_lamp)
      else $error("run lamp dark with terminal bus cycles");

   config_code_a: assert property (nv_checksum_fault && !emc_fault |=>
      err_code_r == ERR_CONFIG && err_arg_r == ARG_ZERO)
      else $error("configuration checksum not shown as code 1");

   command_code_a: assert property (command_fault &&
      {emc_fault, nv_checksum_fault, code_overflow, unknown_type} == 4'h0
      |=> err_code_r == ERR_COMMAND && err_arg_r == ARG_ZERO)
      else $error("command failure not shown as code 3");

   reg_code_a: assert property (reg_comm_fault &&
      {emc_fault, nv_checksum_fault, code_overflow, unknown_type, command_fault,
      chain_break} == 6'h00 |=> err_code_r == ERR_REG_COMM && err_arg_r == $past(reg_term))
      else $error("register fault code or terminal wrong");

   init_code_a: assert property (init_fault &&
      {emc_fault, nv_checksum_fault, code_overflow, unknown_type, command_fault,
      chain_break, reg_comm_fault} == 7'h00
      |=> err_code_r == ERR_INTERNAL && err_arg_r == ARG_ZERO)
      else $error("initialisation failure not shown as code 6");

   overrun_code_a: assert property (overrun_r &&
      {emc_fault, nv_checksum_fault, code_overflow, unknown_type, command_fault, chain_break,
      reg_comm_fault, init_fault, internal_fault, switch_changed} == 10'h000
      |=> err_code_r == ERR_CYCLE && err_arg_r == ARG_ZERO)
      else $error("cycle overrun not shown as code 7");

   warn_lamps_a: assert property (warn_held |=>
      !fieldbus_run_lamp && fieldbus_fault_lamp && fieldbus_diag_lamp)
      else $error("warning level pattern wrong");
endmodule : dle_status_encoder
`default_nettype wire

// *** shared/dle_pkg.sv ***
`default_nettype none
package dle_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 20;
   localparam int FAST_HALF_NS = 50_000_000;
   localparam int SLOW_HALF_NS = 250_000_000;
   // Half periods round down so a flash is never slower than asked
   localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_PERIOD_NS;
   localparam int SLOW_HALF_CYC = SLOW_HALF_NS / CLK_PERIOD_NS;
   localparam int PRESCALE_W = 24;
   localparam int COUNT_W = 8;
   localparam int HALF_W = COUNT_W + 1;

   // ****************************************************************
   // Flash sequence lengths, in half periods
   // ****************************************************************
   localparam logic [HALF_W-1:0] PRE_HALVES = 9'h008;
   localparam logic [HALF_W-1:0] GAP_HALVES = 9'h004;
   localparam logic [HALF_W-1:0] PAUSE_HALVES = 9'h008;

   // ****************************************************************
   // Terminal bus error codes and arguments
   // ****************************************************************
   localparam logic [4:0] ERR_EMC = 5'h00;
   localparam logic [4:0] ERR_CONFIG = 5'h01;
   localparam logic [4:0] ERR_COMMAND = 5'h03;
   localparam logic [4:0] ERR_BREAK = 5'h04;
   localparam logic [4:0] ERR_REG_COMM = 5'h05;
   localparam logic [4:0] ERR_INTERNAL = 5'h06;
   localparam logic [4:0] ERR_CYCLE = 5'h07;
   localparam logic [4:0] ERR_PROGRAM = 5'h09;
   localparam logic [4:0] ERR_MISMATCH = 5'h0A;
   localparam logic [4:0] ERR_FORMAT = 5'h0E;
   localparam logic [4:0] ERR_COUNT = 5'h0F;
   localparam logic [4:0] ERR_LENGTH = 5'h10;
   localparam logic [COUNT_W-1:0] ARG_ZERO = 8'h00;
   localparam logic [COUNT_W-1:0] ARG_ONE = 8'h01;
   localparam logic [COUNT_W-1:0] ARG_TWO = 8'h02;

   // ****************************************************************
   // Fieldbus slow flash counts after the fast preamble
   // ****************************************************************
   localparam logic [COUNT_W-1:0] DIAG_GUARD = 8'h01;
   localparam logic [COUNT_W-1:0] DIAG_SYNC = 8'h02;
   localparam logic [COUNT_W-1:0] DIAG_EVENT = 8'h03;

   typedef enum logic [1:0] {
      NMT_STOPPED = 2'h0,
      NMT_PREOP = 2'h1,
      NMT_OPERATIONAL = 2'h2
   } dle_nmt_t;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'h0,
      SEQ_PRE = 3'h1,
      SEQ_FIRST = 3'h3,
      SEQ_GAP = 3'h2,
      SEQ_SECOND = 3'h6,
      SEQ_PAUSE = 3'h7
   } dle_seq_t;
endpackage : dle_pkg
`default_nettype wire

// *** core/dle_pulse_train.sv ***
`timescale 1ns/1ps
`default_nettype none
module dle_pulse_train
   import dle_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic reset, // Asynchronous reset
   input wire logic fast_tick, // Fast half period pulse
   input wire logic slow_tick, // Slow half period pulse
   input wire logic enable, // Condition to present
   input wire logic [COUNT_W-1:0] count_a, // First slow pulse count
   input wire logic [COUNT_W-1:0] count_b, // Second slow pulse count
   output logic lamp, // Lamp drive
   output logic busy // Sequence in progress
);
   dle_seq_t state_r, state_nxt;
   logic [HALF_W-1:0] half_r, half_nxt;
   logic lamp_r, lamp_nxt;
   logic [COUNT_W-1:0] a_r, b_r;
   wire tick_w;
   wire adv_w;
   wire pulsing_w;
   wire load_w;
   wire [HALF_W-1:0] target_w;

   // ****************************************************************
   // Step decode
   // ****************************************************************
   assign tick_w = (state_r == SEQ_PRE) ? fast_tick : slow_tick;
   assign target_w = (state_r == SEQ_PRE) ? PRE_HALVES :
                     (state_r == SEQ_FIRST) ? {a_r, 1'b0} :
                     (state_r == SEQ_SECOND) ? {b_r, 1'b0} :
                     (state_r == SEQ_GAP) ? GAP_HALVES : PAUSE_HALVES;
   assign adv_w = tick_w && (half_r == target_w) && (state_r != SEQ_IDLE);
   assign pulsing_w = (state_r == SEQ_PRE) || (state_r == SEQ_FIRST) ||
                      (state_r == SEQ_SECOND);
   // Counts are frozen for a whole round so a change never garbles it
   assign load_w = enable && ((state_r == SEQ_IDLE) ||
                              (state_r == SEQ_PAUSE && adv_w));

   always_comb begin
      state_nxt = state_r;
      half_nxt = half_r;
      lamp_nxt = lamp_r;
      case (state_r)
         SEQ_IDLE: begin
            half_nxt = '0;
            lamp_nxt = 1'b0;
            if (enable) begin
               state_nxt = SEQ_PRE;
            end
         end
         SEQ_PRE, SEQ_FIRST, SEQ_GAP, SEQ_SECOND, SEQ_PAUSE: begin
            if (adv_w) begin
               half_nxt = '0;
               lamp_nxt = 1'b0;
               case (state_r)
                  SEQ_PRE: state_nxt = SEQ_FIRST;
                  SEQ_FIRST: state_nxt = SEQ_GAP;
                  SEQ_GAP: state_nxt = SEQ_SECOND;
                  SEQ_SECOND: state_nxt = SEQ_PAUSE;
                  default: state_nxt = enable ? SEQ_PRE : SEQ_IDLE;
               endcase
            end else if (tick_w) begin
               half_nxt = half_r + 1'b1;
               lamp_nxt = pulsing_w ? ~lamp_r : 1'b0;
            end
         end
         default: begin
            state_nxt = SEQ_IDLE;
            half_nxt = '0;
            lamp_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= SEQ_IDLE;
         half_r <= '0;
         lamp_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         half_r <= half_nxt;
         lamp_r <= lamp_nxt;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         a_r <= '0;
         b_r <= '0;
      end else if (load_w) begin
         a_r <= count_a;
         b_r <= count_b;
      end
   end

   assign lamp = lamp_r;
   assign busy = (state_r != SEQ_IDLE);
endmodule : dle_pulse_train
`default_nettype wire

// *** verification/dle_lamp_watch.sv ***
`timescale 1ns/1ps
`default_nettype none
module dle_lamp_watch #(
   parameter int DARK_CYC = 76 // Dark run that closes a flash round
) (
   input wire logic clk, // Bench clock
   input wire logic reset, // Asynchronous reset
   input wire logic clear, // Restart counting
   input wire logic lamp, // Lamp under observation
   output logic [7:0] rises_r, // Turn-ons since clear
   output logic [3:0] rounds_r, // Rounds closed since clear
   output logic [7:0] last_r // Turn-ons in latest round
);
   logic lamp_r;
   logic [7:0] cur_r;
   logic [7:0] dark_r;
   wire logic rise = lamp & ~lamp_r;
   wire logic close = ~lamp & (dark_r == 8'(DARK_CYC - 1)) & (cur_r != 8'h00);
   // ****************************************************************
   // Operator view: count flashes, split rounds at long dark spells
   // ****************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         {lamp_r, cur_r, dark_r, rises_r, rounds_r, last_r} <= '0;
      end else if (clear) begin
         lamp_r <= lamp;
         {cur_r, dark_r, rises_r, rounds_r, last_r} <= '0;
      end else begin
         lamp_r <= lamp;
         rises_r <= rises_r + 8'(rise);
         dark_r <= lamp ? 8'h00 : (dark_r == 8'hFF ? dark_r : dark_r + 8'h01);
         cur_r <= close ? 8'h00 : cur_r + 8'(rise);
         if (close) begin
            last_r <= cur_r;
            rounds_r <= rounds_r + 4'h1;
         end
      end
   end
endmodule : dle_lamp_watch
`default_nettype wire

// *** verification/diagnostic_led_status_encoder_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module diagnostic_led_status_encoder_tb;
   import dle_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic kbus_active = 1'b0;
   logic cycle_overrun = 1'b0;
   logic wclr = 1'b0;
   logic [15:0] flt = 16'h0000;
   logic [7:0] arg_v = 8'h00;
   logic [5:0] fb = 6'h00; // Search, bus-off, warning, guard, sync, event
   dle_nmt_t nmt = NMT_STOPPED;
   logic [31:0] seed = 32'h0001_5DD9;
   int n_mismatch = 0;
   int checks_done = 0;
   logic kb_run, kb_err, f_run, f_fault, f_diag;
   logic [7:0] e_last, d_last, e_rises;
   logic [3:0] e_rounds, d_rounds;
   wire logic [4:0] lamps = {kb_run, kb_err, f_run, f_fault, f_diag};
   int code_t [16] = '{0, 1, 1, 1, 3, 4, 5, 6, 6, 6, 9, 9, 10, 14, 15, 16};
   int argk_t [16] = '{0, 0, 1, 2, 0, -1, -1, 0, 1, 2, 0, 1, -1, -1, -1, -1};
   logic [5:0] fbs_t [6] = '{6'h01, 6'h04, 6'h00, 6'h00, 6'h00, 6'h09};
   dle_nmt_t nmts_t [6] = '{NMT_STOPPED, NMT_STOPPED, NMT_STOPPED, NMT_PREOP,
      NMT_OPERATIONAL, NMT_OPERATIONAL};
   logic [2:0] exps_t [6] = '{3'h0, 3'h3, 3'h6, 3'h6, 3'h4, 3'h0};
   always #10 clk = ~clk;

   dle_status_encoder #(.FAST_CYC(4), .SLOW_CYC(8)) dle_status_encoder_i (
      .clk(clk), .reset(reset), .kbus_active(kbus_active), .emc_fault(flt[0]),
      .nv_checksum_fault(flt[1]), .code_overflow(flt[2]), .unknown_type(flt[3]),
      .command_fault(flt[4]), .chain_break(flt[5]), .break_pos(arg_v),
      .reg_comm_fault(flt[6]), .reg_term(arg_v), .init_fault(flt[7]),
      .internal_fault(flt[8]), .switch_changed(flt[9]), .cycle_overrun(cycle_overrun),
      .program_fault(flt[10]), .library_fault(flt[11]), .config_mismatch(flt[12]),
      .mismatch_term(arg_v), .format_fault(flt[13]), .format_term(arg_v),
      .count_fault(flt[14]), .count_found(arg_v), .length_fault(flt[15]),
      .length_found(arg_v), .fb_baud_search(fb[0]), .fb_bus_off(fb[1]),
      .fb_warning(fb[2]), .fb_nmt_state(nmt), .fb_guard_err(fb[3]), .fb_sync_err(fb[4]),
      .fb_event_timeout(fb[5]), .kbus_run_lamp(kb_run), .kbus_err_lamp(kb_err),
      .fieldbus_run_lamp(f_run), .fieldbus_fault_lamp(f_fault),
      .fieldbus_diag_lamp(f_diag));
   dle_lamp_watch dle_lamp_watch_i (.clk(clk), .reset(reset), .clear(wclr),
      .lamp(kb_err), .rises_r(e_rises), .rounds_r(e_rounds), .last_r(e_last));
   dle_lamp_watch dle_lamp_watch_diag_i (.clk(clk), .reset(reset), .clear(wclr),
      .lamp(f_diag), .rises_r(), .rounds_r(d_rounds), .last_r(d_last));

   // ****************************************************************
   // Bench helpers
   // ****************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [7:0] flashes(input int code, input int arg);
      return 8'(4 + code + arg);
   endfunction : flashes

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wait_rounds(input bit diag, output logic [7:0] seen);
      int i;
      wclr = 1'b1;
      @(negedge clk);
      wclr = 1'b0;
      for (i = 0; i < 4000; i++) begin
         @(negedge clk);
         if ((diag ? d_rounds : e_rounds) >= 4'h2) break;
      end
      if (i == 4000) begin
         n_mismatch++;
         $display("mismatch at %0t: no flash round seen", $time);
         end_of_test();
      end else begin
         seen = diag ? d_last : e_last;
      end
   endtask : wait_rounds

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [7:0] seen;
      int tog;
      logic prev;
      @(negedge clk);
      chk(8'(lamps), 8'h00);
      @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 64; i++) begin
         seed = lfsr(seed);
         prev = seed[0];
         kbus_active = prev;
         @(negedge clk);
         chk(8'(kb_run), 8'(prev));
      end
      for (int i = 0; i < 6; i++) begin
         fb = fbs_t[i];
         nmt = nmts_t[i];
         repeat (3) @(negedge clk);
         chk(8'({f_run, f_fault, f_diag}), 8'(exps_t[i]));
      end
      fb = 6'h02;
      tog = 0;
      prev = f_fault;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         tog += int'(f_fault !== prev);
         prev = f_fault;
      end
      chk(8'(tog > 2), 8'h01);
      chk(8'({f_run, f_diag}), 8'h00);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         fb = 6'h08 << k;
         nmt = dle_nmt_t'(seed[1:0] % 3);
         wait_rounds(1'b1, seen);
         chk(seen, flashes(k + 1, 0));
         chk(8'({f_run, f_fault}), 8'h03);
      end
      fb = 6'h00;
      // Every code and argument pairing but the cycle overrun, random terminal numbers except the chain break at 0
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         kbus_active = seed[8];
         arg_v = (i == 5) ? 8'h00 : 8'(seed[2:0]);
         flt = 16'h0001 << i;
         wait_rounds(1'b0, seen);
         chk(seen, flashes(code_t[i], argk_t[i] < 0 ? int'(arg_v) : argk_t[i]));
      end
      flt = 16'h8001;
      wait_rounds(1'b0, seen);
      chk(seen, flashes(0, 0));
      flt = 16'h0000;
      cycle_overrun = 1'b1;
      @(negedge clk);
      cycle_overrun = 1'b0;
      wait_rounds(1'b0, seen);
      chk(seen, flashes(7, 0));
      wait_rounds(1'b0, seen);
      chk(seen, flashes(7, 0));
      reset = 1'b1;
      repeat (2) @(negedge clk);
      chk(8'(lamps), 8'h00);
      reset = 1'b0;
      wclr = 1'b1;
      @(negedge clk);
      wclr = 1'b0;
      repeat (300) @(negedge clk);
      chk(e_rises, 8'h00);
      end_of_test();
   end
endmodule : diagnostic_led_status_encoder_tb
`default_nettype wire
